// ===== ui_pkg.sv
/*
 * Shared constants and types for the pushbutton and status indicator block.
 * Assumes one 20 MHz clock; all human-scale times run on a 1 ms tick.
 */
`default_nettype none
package ui_pkg;
   localparam int CLK_PERIOD_NS = 50;
   localparam int TICK_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICK_MS = 1;
   typedef logic [14:0] ms_t;
   localparam ms_t SHORT_MIN_T = ms_t'(100 / TICK_MS);
   localparam ms_t SHORT_MAX_T = ms_t'(2000 / TICK_MS);
   localparam ms_t GAP_MIN_T = ms_t'(100 / TICK_MS);
   localparam ms_t GAP_MAX_T = ms_t'(2000 / TICK_MS);
   localparam ms_t KEYGEN_HOLD_T = ms_t'(30000 / TICK_MS);
   localparam ms_t RESET_HOLD_T = ms_t'(3000 / TICK_MS);
   localparam ms_t QUIET_T = ms_t'(3000 / TICK_MS);
   localparam ms_t SEARCH_LIMIT_T = ms_t'(30000 / TICK_MS);
   localparam ms_t QUICK_ON_T = ms_t'(125 / TICK_MS);
   localparam ms_t QUICK_OFF_T = ms_t'(125 / TICK_MS);
   localparam ms_t SLOW_ON_T = ms_t'(500 / TICK_MS);
   localparam ms_t SLOW_OFF_T = ms_t'(500 / TICK_MS);
   localparam ms_t GROUP_GAP_T = ms_t'(500 / TICK_MS);
   localparam logic [2:0] JOIN_PULSES = 3'h1;
   localparam logic [2:0] TEST_PULSES = 3'h3;
   localparam logic [2:0] RESET_PULSES = 3'h4;
   localparam logic [2:0] DONE_REPEATS = 3'h6;
   localparam logic [2:0] FAIL_REPEATS = 3'h3;
   localparam logic [2:0] TEST_REPEATS = 3'h3;
   localparam logic [2:0] CANCEL_REPEATS = 3'h1;
   typedef enum logic [3:0] {
      M_OFF = 4'b0000, M_ADMIN = 4'b0001, M_NODE = 4'b0010, M_XFER = 4'b0011,
      M_DONE = 4'b0100, M_CANCEL = 4'b0101, M_FAIL = 4'b0110, M_LONG = 4'b0111,
      M_TEST1 = 4'b1000, M_TEST2 = 4'b1001, M_TEST3 = 4'b1010
   } led_mode_t;
endpackage
`default_nettype wire

// ===== pb_status_ui.sv
/*
 * Pushbutton press-sequence decoder and status indicator pattern engine.
 * Assumes the pushbutton pin is asynchronous and externally pulled low, and
 * that the pairing controller inputs and RADIO_ACTIVE_IN are on MCLK_IN.
 */
`timescale 1ns/1ps
`default_nettype none
module pb_status_ui
   import ui_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
   input wire logic MCLK_IN,
   input wire logic RESET_N_IN,
   input wire logic PUSHBUTTON_LINE_IN,
   input wire logic ADMIN_SEARCH_IN,
   input wire logic NODE_SEARCH_IN,
   input wire logic KEY_XFER_ACTIVE_IN,
   input wire logic KEY_XFER_DONE_IN,
   input wire logic JOIN_CANCELLED_IN,
   input wire logic PAIR_FAIL_IN,
   input wire logic NET_KEY_PRESENT_IN,
   input wire logic NET_ADDR_PRESENT_IN,
   input wire logic IS_ADMIN_IN,
   input wire logic RADIO_ACTIVE_IN,
   output logic STATUS_INDICATOR_LINE_OUT,
   output logic JOIN_REQ_OUT,
   output logic CANCEL_REQ_OUT,
   output logic KEYGEN_REQ_OUT,
   output logic FACTORY_RESET_REQ_OUT,
   output logic KEY_TEST_REQ_OUT
);
   logic [14:0] div_r;
   logic tick_r;
   logic btn_m_r, btn_s_r, btn_d_r;
   ms_t high_ms_r, low_ms_r, srch_ms_r, ph_r, dur;
   logic [2:0] cnt_r, grp_r, reps;
   logic locked_r, long_r, os_busy_r, on_r, fin_r, done_r;
   logic [1:0] idx_r, nb;
   logic slow_all, slow_first, gap_en, busy, rise, fall;
   led_mode_t os_mode_r, cur_r, sel, test_mode;

   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!RESET_N_IN);

   // ************************************************************
   // Timebase and input conditioning
   // ************************************************************
   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN || div_r == 15'(TICK_CYCLES - 1))
      begin
         div_r <= 15'h0000;
      end
      else
      begin
         div_r <= div_r + 15'h0001;
      end
      tick_r <= RESET_N_IN && div_r == 15'(TICK_CYCLES - 1);
   end

   // Pin is active high; the idle low comes from the outside pull-down
   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         btn_m_r <= 1'b0;
         btn_s_r <= 1'b0;
         btn_d_r <= 1'b0;
      end
      else
      begin
         btn_m_r <= PUSHBUTTON_LINE_IN;
         btn_s_r <= btn_m_r;
         btn_d_r <= btn_s_r;
      end
   end

   assign rise = btn_s_r && !btn_d_r;
   assign fall = !btn_s_r && btn_d_r;
   assign busy = ADMIN_SEARCH_IN || NODE_SEARCH_IN || KEY_XFER_ACTIVE_IN;

   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN || rise)
      begin
         high_ms_r <= 15'h0000;
      end
      else if (tick_r && btn_s_r && high_ms_r != 15'h7fff)
      begin
         high_ms_r <= high_ms_r + 15'h0001;
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN || fall)
      begin
         low_ms_r <= 15'h0000;
      end
      else if (tick_r && !btn_s_r && low_ms_r != 15'h7fff)
      begin
         low_ms_r <= low_ms_r + 15'h0001;
      end
   end

   // ************************************************************
   // Press sequence decoder
   // ************************************************************
   // A single pulse is only acted on once the gap has run out, so that it
   // cannot be mistaken for the start of a test or reset sequence.
   always_ff @(posedge MCLK_IN)
   begin
      JOIN_REQ_OUT <= 1'b0;
      CANCEL_REQ_OUT <= 1'b0;
      KEYGEN_REQ_OUT <= 1'b0;
      FACTORY_RESET_REQ_OUT <= 1'b0;
      KEY_TEST_REQ_OUT <= 1'b0;
      if (!RESET_N_IN)
      begin
         cnt_r <= 3'h0;
         locked_r <= 1'b0;
         long_r <= 1'b0;
      end
      else if (rise)
      begin
         if (cnt_r != 3'h0 && low_ms_r < GAP_MIN_T)
         begin
            cnt_r <= 3'h0;
            locked_r <= 1'b1;
         end
      end
      else if (fall)
      begin
         if (long_r)
         begin
            long_r <= 1'b0;
            FACTORY_RESET_REQ_OUT <= cnt_r == RESET_PULSES;
            cnt_r <= 3'h0;
         end
         else if (!locked_r && high_ms_r >= SHORT_MIN_T && high_ms_r <= SHORT_MAX_T)
         begin
            if (cnt_r == RESET_PULSES)
            begin
               cnt_r <= 3'h0;
               locked_r <= 1'b1;
            end
            else
            begin
               cnt_r <= cnt_r + 3'h1;
            end
         end
         else
         begin
            cnt_r <= 3'h0;
            locked_r <= locked_r || cnt_r != 3'h0;
         end
      end
      else if (btn_s_r && !long_r && !locked_r)
      begin
         if (cnt_r == RESET_PULSES && high_ms_r >= RESET_HOLD_T)
         begin
            long_r <= 1'b1;
         end
         else if (cnt_r == 3'h0 && high_ms_r >= KEYGEN_HOLD_T)
         begin
            long_r <= 1'b1;
            KEYGEN_REQ_OUT <= 1'b1;
         end
      end
      else if (!btn_s_r)
      begin
         if (locked_r && low_ms_r >= QUIET_T)
         begin
            locked_r <= 1'b0;
         end
         if (cnt_r != 3'h0 && low_ms_r > GAP_MAX_T)
         begin
            cnt_r <= 3'h0;
            JOIN_REQ_OUT <= cnt_r == JOIN_PULSES && !busy;
            CANCEL_REQ_OUT <= cnt_r == JOIN_PULSES && busy;
            KEY_TEST_REQ_OUT <= cnt_r == TEST_PULSES;
            locked_r <= cnt_r != JOIN_PULSES && cnt_r != TEST_PULSES;
         end
      end
   end

   // ************************************************************
   // Pattern selection
   // ************************************************************
   always_comb
   begin
      if (!(NET_KEY_PRESENT_IN && NET_ADDR_PRESENT_IN))
      begin
         test_mode = M_TEST1;
      end
      else if (IS_ADMIN_IN)
      begin
         test_mode = M_TEST3;
      end
      else
      begin
         test_mode = M_TEST2;
      end
   end

   // A fresh event replaces the running one-shot, and wins over its end
   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         os_busy_r <= 1'b0;
         os_mode_r <= M_OFF;
      end
      else if (PAIR_FAIL_IN || JOIN_CANCELLED_IN || CANCEL_REQ_OUT || KEY_XFER_DONE_IN || KEY_TEST_REQ_OUT)
      begin
         os_busy_r <= 1'b1;
         if (PAIR_FAIL_IN)
         begin
            os_mode_r <= M_FAIL;
         end
         else if (JOIN_CANCELLED_IN || CANCEL_REQ_OUT)
         begin
            os_mode_r <= M_CANCEL;
         end
         else if (KEY_XFER_DONE_IN)
         begin
            os_mode_r <= M_DONE;
         end
         else
         begin
            os_mode_r <= test_mode;
         end
      end
      else if (done_r)
      begin
         os_busy_r <= 1'b0;
      end
   end

   // Searching is shown for a bounded time even if the controller lingers
   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN || !(ADMIN_SEARCH_IN || NODE_SEARCH_IN))
      begin
         srch_ms_r <= 15'h0000;
      end
      else if (tick_r && srch_ms_r < SEARCH_LIMIT_T)
      begin
         srch_ms_r <= srch_ms_r + 15'h0001;
      end
   end

   always_comb
   begin
      sel = M_OFF;
      if (long_r)
      begin
         sel = M_LONG;
      end
      else if (os_busy_r)
      begin
         sel = os_mode_r;
      end
      else if (KEY_XFER_ACTIVE_IN)
      begin
         sel = M_XFER;
      end
      else if (ADMIN_SEARCH_IN && srch_ms_r < SEARCH_LIMIT_T)
      begin
         sel = M_ADMIN;
      end
      else if (NODE_SEARCH_IN && srch_ms_r < SEARCH_LIMIT_T)
      begin
         sel = M_NODE;
      end
   end

   // ************************************************************
   // Blink engine
   // ************************************************************
   always_comb
   begin
      nb = 2'h1;
      reps = 3'h0;
      slow_all = 1'b0;
      slow_first = 1'b0;
      gap_en = 1'b1;
      unique case (cur_r)
         M_OFF, M_NODE: nb = 2'h1;
         M_ADMIN: nb = 2'h2;
         M_XFER: gap_en = 1'b0;
         M_DONE: begin slow_all = 1'b1; reps = DONE_REPEATS; end
         M_CANCEL: begin nb = 2'h2; reps = CANCEL_REPEATS; end
         M_FAIL: begin slow_all = 1'b1; reps = FAIL_REPEATS; end
         M_LONG: begin nb = 2'h3; slow_first = 1'b1; end
         M_TEST1: reps = TEST_REPEATS;
         M_TEST2: begin nb = 2'h2; reps = TEST_REPEATS; end
         M_TEST3: begin nb = 2'h3; reps = TEST_REPEATS; end
         default: nb = 2'h1;
      endcase
      if (on_r)
      begin
         dur = (slow_all || (slow_first && idx_r == 2'h0)) ? SLOW_ON_T : QUICK_ON_T;
      end
      else
      begin
         dur = (slow_all || (slow_first && idx_r == 2'h0)) ? SLOW_OFF_T : QUICK_OFF_T;
         if (gap_en && idx_r + 2'h1 >= nb)
         begin
            dur = dur + GROUP_GAP_T;
         end
      end
   end

   always_ff @(posedge MCLK_IN)
   begin
      done_r <= 1'b0;
      if (!RESET_N_IN)
      begin
         cur_r <= M_OFF;
         idx_r <= 2'h0;
         grp_r <= 3'h0;
         ph_r <= 15'h0000;
         on_r <= 1'b0;
         fin_r <= 1'b0;
      end
      else if (sel != cur_r)
      begin
         cur_r <= sel;
         idx_r <= 2'h0;
         grp_r <= 3'h0;
         ph_r <= 15'h0000;
         on_r <= sel != M_OFF;
         fin_r <= 1'b0;
      end
      else if (tick_r && cur_r != M_OFF && !fin_r)
      begin
         if (ph_r + 15'h0001 < dur)
         begin
            ph_r <= ph_r + 15'h0001;
         end
         else
         begin
            ph_r <= 15'h0000;
            if (on_r)
            begin
               on_r <= 1'b0;
            end
            else if (idx_r + 2'h1 < nb)
            begin
               idx_r <= idx_r + 2'h1;
               on_r <= 1'b1;
            end
            else if (reps != 3'h0 && grp_r + 3'h1 >= reps)
            begin
               fin_r <= 1'b1;
               done_r <= 1'b1;
            end
            else
            begin
               grp_r <= grp_r + 3'h1;
               idx_r <= 2'h0;
               on_r <= 1'b1;
            end
         end
      end
   end

   // Holding the button overrides everything except the long-hold answer.
   // Stays forced until that pattern has taken over, so no dark blip.
   always_ff @(posedge MCLK_IN)
   begin
      if (!RESET_N_IN)
      begin
         STATUS_INDICATOR_LINE_OUT <= 1'b0;
      end
      else if (btn_s_r && (!long_r || cur_r != M_LONG))
      begin
         STATUS_INDICATOR_LINE_OUT <= 1'b1;
      end
      else if (cur_r == M_OFF)
      begin
         STATUS_INDICATOR_LINE_OUT <= RADIO_ACTIVE_IN;
      end
      else
      begin
         STATUS_INDICATOR_LINE_OUT <= on_r;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   sequence s_fall;
      btn_d_r && !btn_s_r;
   endsequence
   sequence s_good_pulse;
      !long_r && !locked_r && high_ms_r >= SHORT_MIN_T && high_ms_r <= SHORT_MAX_T && cnt_r < RESET_PULSES;
   endsequence

   AST_HOLD_ON: assert property (btn_s_r && !long_r |=> STATUS_INDICATOR_LINE_OUT)
      else $error("Indicator not on while button held");
   AST_IDLE: assert property (cur_r == M_OFF && sel == M_OFF && !btn_s_r
      |=> STATUS_INDICATOR_LINE_OUT == $past(RADIO_ACTIVE_IN))
      else $error("Idle indicator does not follow radio activity");
   AST_KEYGEN: assert property ($rose(KEYGEN_REQ_OUT) |-> $past(high_ms_r) >= KEYGEN_HOLD_T
      && $past(cnt_r) == 3'h0 && long_r)
      else $error("Key generation without full hold");
   AST_FACTORY: assert property (FACTORY_RESET_REQ_OUT |-> $past(long_r) && $past(cnt_r) == RESET_PULSES
      && !long_r)
      else $error("Factory reset without recognised sequence");
   AST_COUNT: assert property (s_fall ##0 s_good_pulse |=> cnt_r == 3'($past(cnt_r) + 3'h1))
      else $error("Short pulse not counted");
   AST_ABORT: assert property (s_fall ##0 (!long_r && high_ms_r > SHORT_MAX_T) |=> cnt_r == 3'h0)
      else $error("Overlong press did not clear the count");
   AST_GAP: assert property (rise && cnt_r != 3'h0 && low_ms_r < GAP_MIN_T |=> cnt_r == 3'h0 && locked_r)
      else $error("Short gap not rejected");
   AST_QUIET: assert property ($fell(locked_r) |-> $past(low_ms_r) >= QUIET_T && !$past(btn_s_r))
      else $error("Lockout released early");
   AST_LONG: assert property (long_r [*2] |-> cur_r == M_LONG)
      else $error("Long hold pattern not running");
   AST_JOIN: assert property (JOIN_REQ_OUT || CANCEL_REQ_OUT |-> JOIN_REQ_OUT != $past(busy)
      && $past(cnt_r) == JOIN_PULSES)
      else $error("Join or cancel chosen wrongly");
   AST_TEST: assert property (KEY_TEST_REQ_OUT |=> os_busy_r && os_mode_r == $past(test_mode))
      else $error("Key test pattern not started");
endmodule // pb_status_ui
`default_nettype wire

// ===== pb_led_model.sv
/*
 * Far-side model: momentary pushbutton with an outside pull-down, and an
 * observer that counts rising edges of the status indicator.
 * Assumes the bench calls set_btn and reads rises_r hierarchically.
 */
`timescale 1ns/1ps
`default_nettype none
module pb_led_model
(
   input wire logic clk_in,
   input wire logic led_in,
   output logic button_out
);
   logic pressed_r = 1'b0;
   logic led_d_r = 1'b0;
   logic [15:0] rises_r = 16'h0000;

   // Released pin sits at the pull-down level, never floats
   assign button_out = pressed_r;

   // Counting edges rather than levels ignores blink phase alignment
   always @(posedge clk_in)
   begin
      led_d_r <= led_in;
      if (led_in && !led_d_r)
      begin
         rises_r <= rises_r + 16'h0001;
      end
   end

   task automatic set_btn(input logic v);
      @(posedge clk_in);
      pressed_r <= v;
   endtask
endmodule // pb_led_model
`default_nettype wire

// ===== pb_status_ui_tb.sv
/*
 * Self-checking bench for the pushbutton decoder and indicator patterns.
 * Assumes one tick per clock (TICK_CYCLES 1), so 1 ms equals one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module pb_status_ui_tb;
   import ui_pkg::*;
   localparam int TK = 1;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic pb;
   logic admin_s = 1'b0;
   logic node_s = 1'b0;
   logic xfer_a = 1'b0;
   logic key_p = 1'b0;
   logic addr_p = 1'b0;
   logic is_adm = 1'b0;
   logic radio = 1'b0;
   logic [2:0] ev = 3'h0;
   logic led;
   logic [4:0] req;
   logic [15:0] base;
   int n_errors = 0;
   int cmp_count = 0;
   // Fail and done windows close in the last, gap-stretched off phase
   int win[3] = '{3600, 1000, 8100};
   logic [15:0] nbl[3] = '{16'h0003, 16'h0002, 16'h0006};

   always #25 mclk = ~mclk;

   pb_status_ui #(.TICK_CYCLES(TK)) i_pb_status_ui (
      .MCLK_IN(mclk), .RESET_N_IN(rst_n), .PUSHBUTTON_LINE_IN(pb),
      .ADMIN_SEARCH_IN(admin_s), .NODE_SEARCH_IN(node_s), .KEY_XFER_ACTIVE_IN(xfer_a),
      .KEY_XFER_DONE_IN(ev[2]), .JOIN_CANCELLED_IN(ev[1]), .PAIR_FAIL_IN(ev[0]),
      .NET_KEY_PRESENT_IN(key_p), .NET_ADDR_PRESENT_IN(addr_p), .IS_ADMIN_IN(is_adm),
      .RADIO_ACTIVE_IN(radio), .STATUS_INDICATOR_LINE_OUT(led), .JOIN_REQ_OUT(req[0]),
      .CANCEL_REQ_OUT(req[1]), .KEYGEN_REQ_OUT(req[2]), .FACTORY_RESET_REQ_OUT(req[3]),
      .KEY_TEST_REQ_OUT(req[4]));

   pb_led_model i_pb_led_model (.clk_in(mclk), .led_in(led), .button_out(pb));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic ms(input int n);
      repeat (n * TK) @(posedge mclk);
      #1;
   endtask

   task automatic btn(input logic v);
      i_pb_led_model.set_btn(v);
   endtask

   task automatic pulses(input int n, input int hi, input int lo);
      for (int i = 0; i < n; i++)
      begin
         btn(1'b1);
         ms(hi);
         btn(1'b0);
         ms(lo);
      end
   endtask

   // Expects exactly the one-hot request vector, no sooner than lo ms
   task automatic wait_req(input string what, input logic [4:0] exp, input int lo, input int hi);
      int t;
      t = 0;
      while (req === 5'h00 && t < hi * TK)
      begin
         @(posedge mclk);
         #1;
         t++;
      end
      chk(what, {11'h000, req}, {11'h000, exp});
      if (exp !== 5'h00)
      begin
         chk({what, " time"}, 16'(t >= lo * TK), 16'h0001);
      end
   endtask

   task automatic count_led(input string what, input int w, input logic [15:0] exp);
      base = i_pb_led_model.rises_r;
      ms(w);
      chk(what, i_pb_led_model.rises_r - base, exp);
   endtask

   task automatic stop_test();
      $display("errors %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_idle();
      chk("idle led", {15'h0000, led}, 16'h0000);
      @(posedge mclk);
      radio <= 1'b1;
      ms(3);
      chk("radio led", {15'h0000, led}, 16'h0001);
      radio <= 1'b0;
      ms(3);
      chk("radio off led", {15'h0000, led}, 16'h0000);
      $display("idle test done");
   endtask

   task automatic t_join();
      btn(1'b1);
      ms(150);
      chk("held led", {15'h0000, led}, 16'h0001);
      ms(150);
      btn(1'b0);
      wait_req("join", 5'h01, 2000, 2010);
      pulses(1, 50, 0);
      wait_req("too short", 5'h00, 0, 2100);
      $display("join test done");
   endtask

   task automatic t_lockout();
      pulses(1, 150, 150);
      pulses(1, 2500, 150);
      pulses(1, 150, 0);
      wait_req("overlong and locked", 5'h00, 0, 2100);
      ms(1000);
      pulses(3, 150, 50);
      wait_req("short gap", 5'h00, 0, 2100);
      ms(1000);
      pulses(1, 150, 0);
      wait_req("after quiet", 5'h01, 2000, 2010);
      $display("lockout test done");
   endtask

   task automatic t_search();
      @(posedge mclk);
      admin_s <= 1'b1;
      count_led("admin blinks", 1900, 16'h0004);
      admin_s <= 1'b0;
      node_s <= 1'b1;
      count_led("node blinks", 1900, 16'h0003);
      pulses(1, 300, 0);
      wait_req("cancel", 5'h02, 2000, 2010);
      node_s <= 1'b0;
      ms(1000);
      xfer_a <= 1'b1;
      count_led("xfer blinks", 1000, 16'h0004);
      xfer_a <= 1'b0;
      ms(200);
      $display("search test done");
   endtask

   task automatic t_oneshot();
      for (int i = 0; i < 3; i++)
      begin
         base = i_pb_led_model.rises_r;
         @(posedge mclk);
         ev <= 3'h1 << i;
         @(posedge mclk);
         ev <= 3'h0;
         ms(win[i]);
         chk("oneshot blinks", i_pb_led_model.rises_r - base, nbl[i]);
      end
      $display("oneshot test done");
   endtask

   task automatic t_keytest();
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         key_p <= (i != 0);
         addr_p <= (i != 0);
         is_adm <= (i == 2);
         pulses(3, 150, 150);
         wait_req("key test", 5'h10, 1850, 2010);
         count_led("test blinks", 3800, 16'(3 * (i + 1)));
      end
      $display("key test done");
   endtask

   task automatic t_freset();
      pulses(4, 150, 150);
      btn(1'b1);
      ms(3100);
      count_led("reset hold blinks", 1300, 16'h0002);
      btn(1'b0);
      wait_req("factory reset", 5'h08, 0, 10);
      ms(1000);
      $display("factory reset test done");
   endtask

   task automatic t_keygen();
      btn(1'b1);
      ms(1000);
      chk("steady led", {15'h0000, led}, 16'h0001);
      wait_req("keygen", 5'h04, 28990, 29020);
      ms(100);
      count_led("keygen hold blinks", 1300, 16'h0002);
      btn(1'b0);
      ms(10);
      chk("released led", {15'h0000, led}, 16'h0000);
      $display("keygen test done");
   endtask

   // ****************************************
   // Sequence and watchdog
   // ****************************************
   initial
   begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      ms(5);
      t_idle();
      t_join();
      t_lockout();
      t_search();
      t_oneshot();
      t_keytest();
      t_freset();
      t_keygen();
      stop_test();
   end

   // Sized a little above the roughly 95k cycles the scenarios need
   initial
   begin
      repeat (98000) @(posedge mclk);
      n_errors++;
      $display("CHECK FAILED watchdog expected done seen timeout");
      stop_test();
   end
endmodule // pb_status_ui_tb
`default_nettype wire
